// *** src/ee_cfg_pkg.sv ***
// constants and carriers shared by the serial eeprom configuration loader
package ee_cfg_pkg;

   // ***********************************************************
   // timing
   // ***********************************************************
   localparam int CLK_NS = 40;
   // serial clock must run at 1 MHz or faster
   localparam int SK_MIN_FREQ_KHZ = 1000;
   localparam int SK_PERIOD_NS = 1000000 / SK_MIN_FREQ_KHZ;
   // longest half period, rounded down to whole cycles
   localparam int SK_HALF_CYC = SK_PERIOD_NS / (2 * CLK_NS);

   // ***********************************************************
   // serial protocol
   // ***********************************************************
   localparam logic [2:0] CMD_READ = 3'h6;  // start bit, then opcode 10
   localparam logic [1:0] CMD_LAST = 2'h2;
   localparam logic [3:0] ALEN_SMALL = 4'h6;
   localparam logic [3:0] ALEN_LARGE = 4'h8;
   localparam logic [4:0] DATA_LAST = 5'hF;
   localparam logic [2:0] NUM_WORDS = 3'h7;

   // ***********************************************************
   // fields of configuration word A
   // ***********************************************************
   localparam int SIG_LSB = 14;
   localparam int REVG_LSB = 13;
   localparam int BRD_BIT = 11;
   localparam int REV_LSB = 8;
   localparam int DPD_BIT = 6;
   localparam int STB_BIT = 1;
   localparam logic [1:0] SIG_VALID = 2'h1;
   localparam logic [2:0] REV_GATE = 3'h3;

   // ***********************************************************
   // defaults and register offsets
   // ***********************************************************
   localparam logic [2:0] DEF_REV = 3'h0;
   localparam logic [15:0] DEF_SUBSYS = 16'h0000;
   localparam logic [47:0] DEF_STATION = 48'h000000000000;
   localparam logic [7:0] REG_STATUS = 8'h00;
   localparam logic [7:0] REG_CONFIG = 8'h04;
   localparam logic [7:0] REG_SUBSYS = 8'h08;
   localparam logic [7:0] REG_STA_LO = 8'h0C;
   localparam logic [7:0] REG_STA_HI = 8'h10;
   localparam logic [7:0] REG_STA_SET = 8'h14;
   localparam logic [7:0] REG_WORD_BASE = 8'h20;
   localparam logic [7:0] REG_WORD_END = 8'h38;

   // ***********************************************************
   // types
   // ***********************************************************
   typedef enum logic [5:0] {
      ST_SEL = 6'h01,
      ST_CMD = 6'h02,
      ST_ADDR = 6'h04,
      ST_DATA = 6'h08,
      ST_GAP = 6'h10,
      ST_DONE = 6'h20
   } state_t;

   typedef struct packed {
      logic sk;
      logic cs;
      logic di;
   } ee_pins_t;

   typedef struct packed {
      logic bootRomDisable;
      logic [2:0] revisionLowBits;
      logic deepPowerdownDisable;
      logic standbyAllow;
      logic [15:0] subsysId;
      logic [15:0] subsysVendorId;
   } cfg_out_t;

endpackage

// *** src/cfg_word_store.sv ***
// small store of the raw words read from the eeprom, registered read
module cfg_word_store #(
   parameter int W = 16,
   parameter int AW = 3
) (
   input wire logic mclk,
   input wire logic srst,
   input wire logic wrEn,
   input wire logic [AW-1:0] wrAddr,
   input wire logic [W-1:0] wrData,
   input wire logic [AW-1:0] rdAddr,
   output logic [W-1:0] rdData
);

   logic [W-1:0] mem [2**AW];

   // storage has no reset; only the read register is cleared
   always_ff @(posedge mclk) begin
      if (wrEn) begin
         mem[wrAddr] <= wrData;
      end
   end

   // read word comes out of a flip-flop, one cycle after the address
   always_ff @(posedge mclk) begin
      if (srst) begin
         rdData <= '0;
      end else begin
         rdData <= mem[rdAddr];
      end
   end

endmodule

// *** src/serial_eeprom_config_loader.sv ***
// serial eeprom configuration loader with register port
//
// Decided for this implementation: the register offsets and the strobed register port.
module serial_eeprom_config_loader #(
   parameter int SK_HALF = ee_cfg_pkg::SK_HALF_CYC,
   parameter logic [2:0] REV_DEFAULT = ee_cfg_pkg::DEF_REV
) (
   input wire logic mclk,
   input wire logic srst,
   input wire logic eeDo,
   output ee_cfg_pkg::ee_pins_t eePins,
   input wire logic [7:0] regAddr,
   input wire logic [31:0] regWrData,
   input wire logic regWr,
   input wire logic regRd,
   output logic [31:0] regRdData,
   input wire logic pmeEnabled,
   input wire logic d3State,
   output ee_cfg_pkg::cfg_out_t cfgOut,
   output logic [47:0] stationAddress,
   output logic expRomBarEnable,
   output logic deepPowerdownAllow,
   output logic busClockRequest,
   output logic loadDone
);
   import ee_cfg_pkg::*;

   // ***********************************************************
   // declarations
   // ***********************************************************
   state_t state_r, state_nxt;
   logic [7:0] divCnt_r;
   logic skInt_r, doMeta_r, doSync_r;
   logic [4:0] bitCnt_r;
   logic [2:0] wIdx_r;
   logic [3:0] addrLen_r;
   logic sizeKnown_r, noDummy_r, ovrOn_r, selMem_r;
   logic [15:0] rxSh_r, wordA_r, memQ;
   logic [47:0] staLoaded_r, staStage_r, staOvr_r;
   cfg_out_t cfg_r, cfgNxt;
   ee_pins_t pins_r;
   logic [31:0] rdData_r, rdMux;

   // eeprom word address for each step of the load
   function automatic logic [7:0] wordAddr(input logic [2:0] idx);
      case (idx)
         3'h0: wordAddr = 8'h00;
         3'h1: wordAddr = 8'h01;
         3'h2: wordAddr = 8'h02;
         3'h3: wordAddr = 8'h0A;
         3'h4: wordAddr = 8'h0B;
         3'h5: wordAddr = 8'h0C;
         default: wordAddr = 8'h0D;
      endcase
   endfunction

   // ***********************************************************
   // serial clock and bit timing
   // ***********************************************************
   wire stCmd = (state_r == ST_CMD);
   wire stAddr = (state_r == ST_ADDR);
   wire stData = (state_r == ST_DATA);
   wire shifting = stCmd | stAddr | stData;
   wire tick = (divCnt_r == 8'(SK_HALF - 1));
   wire fallTick = tick & skInt_r;
   wire csNxt = shifting | (state_r == ST_SEL);
   wire [7:0] curAddr = wordAddr(wIdx_r);
   wire [1:0] cmdIdx = CMD_LAST - bitCnt_r[1:0];
   wire [3:0] aLen = sizeKnown_r ? addrLen_r : ALEN_LARGE;
   wire [3:0] aIdx = aLen - 4'h1 - bitCnt_r[3:0];
   wire addrLastBit = (bitCnt_r[3:0] == aLen - 4'h1);
   // dummy zero ends the address while size is unknown
   wire dummySeen = ~sizeKnown_r & ~doSync_r;
   wire addrEnd = addrLastBit | dummySeen;
   wire [15:0] newWord = {rxSh_r[14:0], doSync_r};
   wire wordDone = stData & fallTick & (bitCnt_r == DATA_LAST);
   wire cmdLast = (bitCnt_r[1:0] == CMD_LAST);
   wire lastWord = (wIdx_r == NUM_WORDS);
   // command bits go out first, then the address
   wire diNxt = stCmd ? CMD_READ[cmdIdx] :
                stAddr ? curAddr[aIdx[2:0]] : 1'b0;

   // divider runs freely; the serial clock only toggles while shifting
   always_ff @(posedge mclk) begin
      if (srst | tick) begin
         divCnt_r <= '0;
      end else begin
         divCnt_r <= divCnt_r + 8'h01;
      end
   end

   always_ff @(posedge mclk) begin
      if (srst | ~shifting) begin
         skInt_r <= 1'b0;
      end else if (tick) begin
         skInt_r <= ~skInt_r;
      end
   end

   // data from the eeprom passes two flops before anything reads it
   always_ff @(posedge mclk) begin
      if (srst) begin
         doMeta_r <= 1'b1;
         doSync_r <= 1'b1;
      end else begin
         doMeta_r <= eeDo;
         doSync_r <= doMeta_r;
      end
   end

   // pins are registered so the eeprom sees glitch-free levels
   always_ff @(posedge mclk) begin
      if (srst) begin
         pins_r <= '0;
      end else begin
         pins_r <= '{sk: skInt_r, cs: csNxt, di: diNxt};
      end
   end
   assign eePins = pins_r;

   // ***********************************************************
   // load sequencer
   // ***********************************************************
   always_comb begin
      state_nxt = state_r;
      case (state_r)
         ST_SEL: if (tick) state_nxt = ST_CMD;
         ST_CMD: if (fallTick && cmdLast) state_nxt = ST_ADDR;
         // address length follows the detected size
         ST_ADDR: if (fallTick && addrEnd) state_nxt = ST_DATA;
         ST_DATA: if (wordDone) state_nxt = ST_GAP;
         ST_GAP: if (tick) state_nxt = lastWord ? ST_DONE : ST_SEL;
         ST_DONE: state_nxt = ST_DONE;
         default: state_nxt = ST_SEL;
      endcase
   end

   always_ff @(posedge mclk) begin
      if (srst) begin
         state_r <= ST_SEL;
      end else begin
         state_r <= state_nxt;
      end
   end

   // bit counter restarts on every state change
   always_ff @(posedge mclk) begin
      if (srst || state_nxt != state_r) begin
         bitCnt_r <= '0;
      end else if (fallTick) begin
         bitCnt_r <= bitCnt_r + 5'h01;
      end
   end

   // size is fixed at the end of the first address, by a dummy zero or by the eighth bit, never by software
   always_ff @(posedge mclk) begin
      if (srst) begin
         sizeKnown_r <= 1'b0;
         noDummy_r <= 1'b0;
         addrLen_r <= ALEN_LARGE;
      end else if (stAddr && fallTick && !sizeKnown_r && addrEnd) begin
         sizeKnown_r <= 1'b1;
         noDummy_r <= ~dummySeen;
         addrLen_r <= (bitCnt_r[3:0] < ALEN_LARGE - 4'h1) ?
                      ALEN_SMALL : ALEN_LARGE;
      end
   end

   // data bits are sampled as the serial clock falls
   always_ff @(posedge mclk) begin
      if (srst) begin
         rxSh_r <= '0;
         wIdx_r <= '0;
      end else if (stData && fallTick) begin
         rxSh_r <= newWord;
         wIdx_r <= wIdx_r + 3'(wordDone);
      end
   end

   // words 0 to 2 fill the station address, low byte earliest
   always_ff @(posedge mclk) begin
      if (srst) begin
         staLoaded_r <= DEF_STATION;
         wordA_r <= '0;
      end else if (wordDone && wIdx_r < 3'h3) begin
         staLoaded_r[{wIdx_r[1:0], 4'h0} +: 16] <= newWord;
      end else if (wordDone && wIdx_r == 3'h3) begin
         wordA_r <= newWord;
      end
   end

   // raw words kept for software readback, word D included
   cfg_word_store #(.W(16), .AW(3)) wordStore (
      .mclk(mclk),
      .srst(srst),
      .wrEn(wordDone),
      .wrAddr(wIdx_r),
      .wrData(newWord),
      .rdAddr(regAddr[4:2]),
      .rdData(memQ)
   );

   // ***********************************************************
   // configuration outputs
   // ***********************************************************
   assign loadDone = (state_r == ST_DONE);
   // nothing loaded counts until the whole load has ended
   wire sigOk = loadDone & (wordA_r[SIG_LSB +: 2] == SIG_VALID);
   wire revGate = (wordA_r[REVG_LSB +: 3] == REV_GATE);
   wire [15:0] subIdQ, subVenQ;
   logic [15:0] subId_r, subVen_r;

   // words B and C feed the subsystem identifiers
   always_ff @(posedge mclk) begin
      if (srst) begin
         subId_r <= DEF_SUBSYS;
         subVen_r <= DEF_SUBSYS;
      end else if (wordDone && wIdx_r == 3'h4) begin
         subId_r <= newWord;
      end else if (wordDone && wIdx_r == 3'h5) begin
         subVen_r <= newWord;
      end
   end
   assign subIdQ = sigOk ? subId_r : DEF_SUBSYS;
   assign subVenQ = sigOk ? subVen_r : DEF_SUBSYS;

   // bad signature means every field takes its default
   always_comb begin
      cfgNxt = '{bootRomDisable: 1'b0, revisionLowBits: REV_DEFAULT,
                 deepPowerdownDisable: 1'b0, standbyAllow: 1'b0,
                 subsysId: subIdQ, subsysVendorId: subVenQ};
      if (sigOk) begin
         cfgNxt.bootRomDisable = wordA_r[BRD_BIT];
         cfgNxt.deepPowerdownDisable = wordA_r[DPD_BIT];
         cfgNxt.standbyAllow = wordA_r[STB_BIT];
         // revision bits need the 011b pattern and a valid signature
         if (revGate) begin
            cfgNxt.revisionLowBits = wordA_r[REV_LSB +: 3];
         end
      end
   end

   // software override wins once the set command has been written
   wire [47:0] staNxt = ovrOn_r ? staOvr_r :
                        sigOk ? staLoaded_r : DEF_STATION;
   always_ff @(posedge mclk) begin
      if (srst) begin
         cfg_r <= '0;
         stationAddress <= DEF_STATION;
      end else begin
         cfg_r <= cfgNxt;
         stationAddress <= staNxt;
      end
   end
   assign cfgOut = cfg_r;

   // boot rom disable turns the expansion rom bar off
   assign expRomBarEnable = ~cfg_r.bootRomDisable;
   // deep power-down only in D3 with PME off and bit clear
   assign deepPowerdownAllow = d3State & ~pmeEnabled &
                               ~cfg_r.deepPowerdownDisable;
   // without standby the bus clock is requested all the time
   assign busClockRequest = ~cfg_r.standbyAllow;

   // ***********************************************************
   // register port
   // ***********************************************************
   wire wrLo = regWr && regAddr == REG_STA_LO;
   wire wrHi = regWr && regAddr == REG_STA_HI;
   wire wrSet = regWr && regAddr == REG_STA_SET;
   wire selMem = regAddr >= REG_WORD_BASE && regAddr <= REG_WORD_END;

   // new station address is staged, then committed by one write
   always_ff @(posedge mclk) begin
      if (srst) begin
         staStage_r <= DEF_STATION;
         staOvr_r <= DEF_STATION;
         ovrOn_r <= 1'b0;
      end else begin
         if (wrLo) staStage_r[31:0] <= regWrData;
         if (wrHi) staStage_r[47:32] <= regWrData[15:0];
         if (wrSet) staOvr_r <= staStage_r;
         if (wrSet) ovrOn_r <= 1'b1;
      end
   end

   // address decode for reads; unmapped offsets read as zero
   always_comb begin
      if (regAddr == REG_STATUS) begin
         rdMux = {28'h0, noDummy_r, sigOk, addrLen_r == ALEN_LARGE,
                  loadDone};
      end else if (regAddr == REG_CONFIG) begin
         rdMux = {26'h0, cfg_r.bootRomDisable, cfg_r.revisionLowBits,
                  cfg_r.deepPowerdownDisable, cfg_r.standbyAllow};
      end else if (regAddr == REG_SUBSYS) begin
         rdMux = {cfg_r.subsysVendorId, cfg_r.subsysId};
      end else if (regAddr == REG_STA_LO) begin
         rdMux = stationAddress[31:0];
      end else if (regAddr == REG_STA_HI) begin
         rdMux = {16'h0, stationAddress[47:32]};
      end else begin
         rdMux = 32'h0;
      end
   end

   // read data stand only in the cycle after the strobe
   always_ff @(posedge mclk) begin
      if (srst) begin
         rdData_r <= '0;
         selMem_r <= 1'b0;
      end else begin
         rdData_r <= regRd ? rdMux : 32'h0;
         selMem_r <= regRd & selMem;
      end
   end
   assign regRdData = selMem_r ? {16'h0, memQ} : rdData_r;

   // ***********************************************************
   // assertions
   // ***********************************************************
   default clocking cb @(posedge mclk); endclocking
   default disable iff (srst);

   a_cmd_first: assert property (
      $rose(stCmd) |-> ##1 eePins.cs && eePins.di && !eePins.sk)
      else $error("command start bit missing");
   a_addr_len: assert property (
      stAddr && fallTick && sizeKnown_r &&
      bitCnt_r[3:0] == addrLen_r - 4'h1 |=> stData)
      else $error("address length wrong");
   a_dummy_zero: assert property (
      stAddr && fallTick && !sizeKnown_r && !doSync_r && bitCnt_r == 5'h5
      |=> stData && sizeKnown_r && addrLen_r == ALEN_SMALL)
      else $error("dummy zero not used as address end");
   a_size_fixed: assert property (
      sizeKnown_r |=> sizeKnown_r && $stable(addrLen_r))
      else $error("detected size changed during load");
   a_seven_words: assert property (
      $rose(loadDone) |-> wIdx_r == NUM_WORDS && $past(state_r) == ST_GAP)
      else $error("load ended with wrong word count");
   a_sig_default: assert property (
      !sigOk |=> !cfg_r.bootRomDisable && cfg_r.subsysId == DEF_SUBSYS &&
      cfg_r.revisionLowBits == REV_DEFAULT)
      else $error("defaults not applied");
   a_rom_bar: assert property (
      sigOk && wordA_r[BRD_BIT] |-> ##1 !expRomBarEnable)
      else $error("expansion rom bar not disabled");
   a_rev_gate: assert property (
      sigOk && revGate |=> cfg_r.revisionLowBits == $past(wordA_r[10:8]))
      else $error("revision bits not taken");
   a_dpd_gate: assert property (
      cfg_r.deepPowerdownDisable |-> !deepPowerdownAllow)
      else $error("deep power-down allowed while disabled");
   a_station_ovr: assert property (
      ovrOn_r |=> stationAddress == $past(staOvr_r))
      else $error("override station address not used");

   c_load_small: cover property ($rose(loadDone) && addrLen_r == ALEN_SMALL);
   c_load_large: cover property ($rose(loadDone) && addrLen_r == ALEN_LARGE);
   c_sig_bad: cover property ($rose(loadDone) ##1 !sigOk);
   c_override: cover property ($rose(ovrOn_r));

endmodule

// *** sim/ee_model.sv ***
// behavioural serial eeprom of 64 or 256 words facing the loader
module ee_model (
   input wire logic big,
   input wire logic sk,
   input wire logic cs,
   input wire logic di,
   output logic eeDo
);
   timeunit 1ns;
   timeprecision 1ps;

   logic [15:0] mem [0:255];
   logic [7:0] seen [$];
   logic [7:0] addr;
   logic [15:0] sh;
   logic drive, dout, cmdErr;
   int cnt, aBits;

   // address length follows the part size chosen by the bench
   assign aBits = big ? 8 : 6;

   initial begin
      cnt = 0;
      drive = 1'b0;
      cmdErr = 1'b0;
      addr = 8'h00;
      dout = 1'b1;
   end

   always @(posedge sk or negedge cs) begin
      if (!cs) begin
         cnt <= 0;
         drive <= 1'b0;
         addr <= 8'h00;
      end else begin
         cnt <= cnt + 1;
         if (cnt < 3 && di !== (cnt != 2)) cmdErr <= 1'b1; // start 1, op 10
         if (cnt >= 3) addr <= {addr[6:0], di};
         if (cnt == aBits + 2) begin
            drive <= 1'b1;
            dout <= 1'b0;
            sh <= mem[{addr[6:0], di}];
            seen.push_back({addr[6:0], di});
         end else if (drive) begin
            dout <= sh[15];
            sh <= {sh[14:0], 1'b0};
         end
      end
   end

   // a released line reads high through the pull-up, never a stale bit
   assign eeDo = (cs && drive) ? dout : 1'b1;
endmodule

// *** sim/tb.sv ***
// self-checking bench for the serial eeprom configuration loader
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   import ee_cfg_pkg::*;

   // word addresses of the automatic load, first word in the low byte
   localparam logic [55:0] WADDR = 56'h0D0C0B0A020100;
   logic mclk, srst, regWr, regRd, pmeEnabled, d3State, big, eeDo;
   logic [7:0] regAddr;
   logic [31:0] regWrData, regRdData, seed, rd;
   ee_pins_t eePins;
   cfg_out_t cfgOut, e;
   logic [47:0] stationAddress;
   logic expRomBarEnable, deepPowerdownAllow, busClockRequest, loadDone;
   int miscompares, check_count;
   logic [15:0] w [0:6];

   // short serial clock half period keeps the 320 ns link rate
   serial_eeprom_config_loader #(.SK_HALF(4)) dut (
      .mclk(mclk), .srst(srst), .eeDo(eeDo), .eePins(eePins),
      .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr),
      .regRd(regRd), .regRdData(regRdData), .pmeEnabled(pmeEnabled),
      .d3State(d3State), .cfgOut(cfgOut), .stationAddress(stationAddress),
      .expRomBarEnable(expRomBarEnable),
      .deepPowerdownAllow(deepPowerdownAllow),
      .busClockRequest(busClockRequest), .loadDone(loadDone));

   ee_model ee (.big(big), .sk(eePins.sk), .cs(eePins.cs),
      .di(eePins.di), .eeDo(eeDo));

   initial begin
      mclk = 1'b0;
      forever #20 mclk = ~mclk;
   end

   // ***********************************************************
   // helpers
   // ***********************************************************
   function logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction

   // expected consumer values; defaults unless the marker is good
   function automatic cfg_out_t expCfg(logic [15:0] a, logic [15:0] b,
         logic [15:0] c, logic ok);
      cfg_out_t x;
      x = '0;
      x.revisionLowBits = DEF_REV;
      if (ok) begin
         x.bootRomDisable = a[BRD_BIT];
         if (a[15:13] == REV_GATE) x.revisionLowBits = a[10:8];
         x.deepPowerdownDisable = a[DPD_BIT];
         x.standbyAllow = a[STB_BIT];
         x.subsysId = b;
         x.subsysVendorId = c;
      end
      return x;
   endfunction

   task check(input logic [63:0] seen, input logic [63:0] exp);
      check_count++;
      if (seen !== exp) begin
         miscompares++;
         $display("unexpected at %0t: got %h expected %h", $time, seen, exp);
      end
   endtask

   task regWrite(input logic [7:0] a, input logic [31:0] d);
      @(posedge mclk);
      regWr <= 1'b1;
      regAddr <= a;
      regWrData <= d;
      @(posedge mclk);
      regWr <= 1'b0;
   endtask

   // read data stand only in the cycle after the strobe
   task regRead(input logic [7:0] a, output logic [31:0] d);
      @(posedge mclk);
      regRd <= 1'b1;
      regAddr <= a;
      @(posedge mclk);
      regRd <= 1'b0;
      #1;
      d = regRdData;
   endtask

   task end_of_test();
      $display("checks %0d mismatches %0d", check_count, miscompares);
      if (miscompares == 0 && check_count > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   // ***********************************************************
   // one load from reset, then checks of everything it feeds
   // ***********************************************************
   task runLoad(input int t);
      logic good;
      logic [15:0] a;
      logic [47:0] sa;
      int n;
      logic deep_powerdown_disable;
      good = (t != 2);
      for (int i = 0; i < 7; i++) w[i] = 16'(rnd());
      a = w[3];
      {a[12], a[7], a[5]} = 3'h0;
      a[15:14] = good ? SIG_VALID : 2'h3;
      a[13] = t[0];
      // both levels of boot rom and deep power-down bits get exercised
      a[BRD_BIT] = t[0];
      a[DPD_BIT] = ~t[0];
      w[3] = a;
      for (int i = 0; i < 7; i++) ee.mem[WADDR[8*i +: 8]] = w[i];
      ee.seen.delete();
      @(posedge mclk);
      big <= t[0];
      srst <= 1'b1;
      repeat (3) @(posedge mclk);
      srst <= 1'b0;
      @(posedge mclk);
      #1;
      check(cfgOut, 0);
      check(stationAddress, 0);
      check(loadDone, 0);
      n = 0;
      while (loadDone !== 1'b1 && n < 20000) begin
         @(posedge mclk);
         #1;
         n++;
      end
      // consumer registers take the loaded words one cycle after done
      @(posedge mclk);
      #1;
      check(loadDone, 1);
      check(ee.seen.size(), 7);
      for (int i = 0; i < ee.seen.size() && i < 7; i++)
         check(ee.seen[i], WADDR[8*i +: 8]);
      check(ee.cmdErr, 0);
      e = expCfg(w[3], w[4], w[5], good);
      check(cfgOut, e);
      sa = good ? {w[2], w[1], w[0]} : DEF_STATION;
      check(stationAddress, sa);
      check(expRomBarEnable, !e.bootRomDisable);
      check(busClockRequest, !e.standbyAllow);
      for (int k = 0; k < 4; k++) begin
         @(posedge mclk);
         d3State <= k[0];
         pmeEnabled <= k[1];
         #1;
         deep_powerdown_disable = k[0] & !k[1] & !e.deepPowerdownDisable;
         check(deepPowerdownAllow, deep_powerdown_disable);
      end
      regRead(REG_STATUS, rd);
      check(rd, {28'h0, 1'b0, good, t[0], 1'b1});
      regRead(REG_CONFIG, rd);
      check(rd, {26'h0, e.bootRomDisable, e.revisionLowBits,
         e.deepPowerdownDisable, e.standbyAllow});
      regRead(REG_SUBSYS, rd);
      check(rd, {e.subsysVendorId, e.subsysId});
      for (int i = 0; i < 7; i++) begin
         regRead(REG_WORD_BASE + 8'(4 * i), rd);
         check(rd, {16'h0, w[i]});
      end
      // unmapped place reads as zero
      regRead(8'h3C, rd);
      check(rd, 0);
      // software address replaces the loaded one after commit
      rd = rnd();
      sa[47:32] = rd[15:0];
      sa[31:0] = rnd();
      regWrite(REG_STA_LO, sa[31:0]);
      regWrite(REG_STA_HI, {16'h0, sa[47:32]});
      regWrite(REG_STA_SET, rnd());
      @(posedge mclk);
      #1;
      check(stationAddress, sa);
      regRead(REG_STA_HI, rd);
      check(rd, {16'h0, sa[47:32]});
      $display("test %0d done", t);
   endtask

   // ***********************************************************
   // main sequence and watchdog
   // ***********************************************************
   initial begin
      seed = 32'h00000046;
      miscompares = 0;
      check_count = 0;
      srst = 1'b1;
      regWr = 1'b0;
      regRd = 1'b0;
      regAddr = 8'h00;
      regWrData = 32'h00000000;
      pmeEnabled = 1'b0;
      d3State = 1'b0;
      big = 1'b0;
      // small good, large good with revision gate, small bad marker
      for (int t = 0; t < 3; t++) runLoad(t);
      end_of_test();
   end

   // three loads need about 4600 cycles; allow five times that
   initial begin
      #1000000;
      miscompares++;
      $display("unexpected at %0t: watchdog expired", $time);
      end_of_test();
   end
endmodule
